// file: core/exec_map.svh
// Offsets, field positions, reset values, opcode patterns and timing counts of the executor.
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

// Register offsets on the software port.
`define REG_CTRL        3'h0
`define REG_WORKING     3'h1
`define REG_STATUS      3'h2
`define REG_PC_LO       3'h3
`define REG_PC_HI       3'h4

// Field positions and widths.
`define CTRL_INT_EN_BIT 0
`define STATUS_C_BIT    0
`define STATUS_Z_BIT    2
`define PC_HI_W         5

// Reset values.
`define RST_WORKING     8'h00
`define RST_PC          13'h0000
`define RST_FLAG        1'b0
`define RST_INT_EN      1'b0

// Master clocks per instruction cycle.
`define CYC_DIV_DEFAULT 4

// Opcode masks and match patterns; masked-out bits are don't-care.
`define MASK_FILE_OP    14'h3f00
`define MATCH_MOVE_FILE 14'h0800
`define MATCH_ROTATE    14'h0d00
`define MASK_STORE      14'h3f80
`define MATCH_STORE     14'h0080
`define MASK_RETFI      14'h3fff
`define MATCH_RETFI     14'h0009
`define MASK_NOP        14'h3f9f
`define MATCH_NOP       14'h0000
`define MASK_LITERAL    14'h3c00
`define MATCH_LOAD_LIT  14'h3000
`define MATCH_RET_LIT   14'h3400

// Operand fields.
`define DEST_BIT        7
`define FADDR_MSB       6
`define LIT_MSB         7

`endif

// file: core/exec_pkg.sv
// Types shared by the instruction executor and its surroundings.
package exec_pkg;

    typedef enum logic [2:0] {
        OP_NONE        = 3'h0,
        OP_MOVE_FILE   = 3'h1,
        OP_NOP         = 3'h2,
        OP_LOAD_LIT    = 3'h3,
        OP_RETFI       = 3'h4,
        OP_STORE       = 3'h5,
        OP_RET_LIT     = 3'h6,
        OP_ROTATE      = 3'h7
    } op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_READ = 2'h1,
        ST_WAIT = 2'h2
    } state_e;

    typedef struct packed {
        op_e        op;
        logic       dest;
        logic [6:0] faddr;
        logic [7:0] lit;
    } instr_s;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [6:0] addr;
        logic [7:0] data;
    } file_req_s;

endpackage

// file: core/move_return_rotate_exec.sv
// Executor for the move, literal, store, return, no-operation and rotate instructions.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "exec_map.svh"

// Summary of operation
// - move_file_op copies file register to working when d is 0, else back to file.
// - move_file_op sets the zero flag from the moved value for either destination.
// - load_literal_op puts the eight-bit literal into working, flags unchanged.
// - Unused bits of load_literal_op are ignored by the decoder.
// - return_from_interrupt_op pops stack top into PC and sets interrupt enable.
// - store_working_op writes working into the addressed file register, flags unchanged.
// - return_with_literal_op loads literal into working and stack top into PC.
// - return_with_literal_op takes two instruction cycles.
// - rotate_left_carry_op shifts left, old carry into bit 0, bit 7 into carry.
// - rotate_left_carry_op result goes to working when d is 0, else to file.
module move_return_rotate_exec #(
    parameter int CYC_DIV = `CYC_DIV_DEFAULT
) (
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    input  wire logic                 instr_valid,
    input  wire logic [13:0]          instr_word,
    output var  logic                 instr_ready,
    output var  exec_pkg::file_req_s  file_req,
    input  wire logic [7:0]           file_rd_data,
    input  wire logic [12:0]          stack_top_entry,
    output var  logic                 stack_pop,
    output var  logic [12:0]          pc,
    output var  logic [7:0]           working,
    output var  logic                 zero_flag,
    output var  logic                 carry_flag,
    output var  logic                 global_interrupt_enable,
    input  wire logic [2:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_write,
    input  wire logic                 reg_read,
    output var  logic [7:0]           reg_rdata
);

    localparam int DIV_W = (CYC_DIV > 2) ? $clog2(CYC_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYC_DIV - 1);

    logic [DIV_W-1:0]     div_cnt;
    logic [DIV_W-1:0]     next_div_cnt;
    logic                 cyc_en;
    logic                 next_cyc_en;

    exec_pkg::state_e     state;
    exec_pkg::state_e     next_state;
    exec_pkg::instr_s     cur;
    exec_pkg::instr_s     next_cur;
    exec_pkg::instr_s     dec;
    exec_pkg::file_req_s  next_file_req;

    logic                 next_instr_ready;
    logic                 next_stack_pop;
    logic [12:0]          next_pc;
    logic [7:0]           next_working;
    logic                 next_zero_flag;
    logic                 next_carry_flag;
    logic                 next_global_interrupt_enable;
    logic [7:0]           next_reg_rdata;
    logic [7:0]           result;
    logic                 take;

    // Returns true when the word matches the pattern in the bits the mask keeps.
    function automatic logic hit(
        input logic [13:0] word,
        input logic [13:0] mask,
        input logic [13:0] match
    );
        hit = ((word & mask) == match);
    endfunction

    // Splits an instruction word into operation and operand fields.
    function automatic exec_pkg::instr_s decode(input logic [13:0] word);
        exec_pkg::instr_s d;
        d.op    = exec_pkg::OP_NONE;
        d.dest  = word[`DEST_BIT];
        d.faddr = word[`FADDR_MSB:0];
        d.lit   = word[`LIT_MSB:0];
        if (hit(word, `MASK_FILE_OP, `MATCH_MOVE_FILE)) begin
            d.op = exec_pkg::OP_MOVE_FILE;
        end else if (hit(word, `MASK_FILE_OP, `MATCH_ROTATE)) begin
            d.op = exec_pkg::OP_ROTATE;
        end else if (hit(word, `MASK_STORE, `MATCH_STORE)) begin
            d.op = exec_pkg::OP_STORE;
        end else if (hit(word, `MASK_RETFI, `MATCH_RETFI)) begin
            d.op = exec_pkg::OP_RETFI;
        end else if (hit(word, `MASK_NOP, `MATCH_NOP)) begin
            d.op = exec_pkg::OP_NOP;
        end else if (hit(word, `MASK_LITERAL, `MATCH_LOAD_LIT)) begin
            d.op = exec_pkg::OP_LOAD_LIT;
        end else if (hit(word, `MASK_LITERAL, `MATCH_RET_LIT)) begin
            d.op = exec_pkg::OP_RET_LIT;
        end
        return d;
    endfunction

    // Instruction cycle divider.
    always_comb begin
        if (div_cnt == DIV_LAST) begin
            next_div_cnt = '0;
            next_cyc_en  = 1'b1;
        end else begin
            next_div_cnt = div_cnt + 1'b1;
            next_cyc_en  = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            div_cnt <= '0;
            cyc_en  <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            cyc_en  <= next_cyc_en;
        end
    end

    assign dec  = decode(instr_word);
    assign take = instr_valid && instr_ready && cyc_en;

    // Rotated or moved value formed from the file data returned this cycle.
    always_comb begin
        if (cur.op == exec_pkg::OP_ROTATE) begin
            result = {file_rd_data[6:0], carry_flag};
        end else begin
            result = file_rd_data;
        end
    end

    // Execution sequence; software writes apply first and execution overrides them.
    always_comb begin
        next_state          = state;
        next_cur            = cur;
        next_pc             = pc;
        next_working        = working;
        next_zero_flag      = zero_flag;
        next_carry_flag     = carry_flag;
        next_global_interrupt_enable = global_interrupt_enable;
        next_stack_pop      = 1'b0;
        next_file_req       = file_req;
        next_file_req.rd    = 1'b0;
        next_file_req.wr    = 1'b0;

        if (reg_write) begin
            case (reg_addr)
                `REG_CTRL: begin
                    next_global_interrupt_enable = reg_wdata[`CTRL_INT_EN_BIT];
                end
                `REG_WORKING: begin
                    next_working = reg_wdata;
                end
                `REG_STATUS: begin
                    next_zero_flag  = reg_wdata[`STATUS_Z_BIT];
                    next_carry_flag = reg_wdata[`STATUS_C_BIT];
                end
                default: begin
                    next_global_interrupt_enable = global_interrupt_enable;
                end
            endcase
        end

        case (state)
            exec_pkg::ST_IDLE: begin
                if (take) begin
                    next_cur = dec;
                    next_pc  = pc + 13'h0001;
                    case (dec.op)
                        exec_pkg::OP_MOVE_FILE, exec_pkg::OP_ROTATE: begin
                            next_file_req.rd   = 1'b1;
                            next_file_req.addr = dec.faddr;
                            next_state         = exec_pkg::ST_READ;
                        end
                        exec_pkg::OP_LOAD_LIT: begin
                            next_working = dec.lit;
                        end
                        exec_pkg::OP_STORE: begin
                            next_file_req.wr   = 1'b1;
                            next_file_req.addr = dec.faddr;
                            next_file_req.data = next_working;
                        end
                        exec_pkg::OP_RETFI: begin
                            next_pc        = stack_top_entry;
                            next_stack_pop = 1'b1;
                            next_global_interrupt_enable = 1'b1;
                            next_state     = exec_pkg::ST_WAIT;
                        end
                        exec_pkg::OP_RET_LIT: begin
                            next_working   = dec.lit;
                            next_pc        = stack_top_entry;
                            next_stack_pop = 1'b1;
                            next_state     = exec_pkg::ST_WAIT;
                        end
                        default: begin
                            next_state = exec_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
            exec_pkg::ST_READ: begin
                if (cur.op == exec_pkg::OP_MOVE_FILE) begin
                    next_zero_flag = (result == 8'h00);
                end else begin
                    next_carry_flag = file_rd_data[7];
                end
                if (cur.dest) begin
                    next_file_req.wr   = 1'b1;
                    next_file_req.data = result;
                end else begin
                    next_working = result;
                end
                next_state = exec_pkg::ST_IDLE;
            end
            exec_pkg::ST_WAIT: begin
                if (cyc_en) begin
                    next_state = exec_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = exec_pkg::ST_IDLE;
            end
        endcase

        next_instr_ready = (next_state == exec_pkg::ST_IDLE);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state                   <= exec_pkg::ST_IDLE;
            cur                     <= '0;
            instr_ready             <= 1'b1;
            file_req                <= '0;
            stack_pop               <= 1'b0;
            pc                      <= `RST_PC;
            working                 <= `RST_WORKING;
            zero_flag               <= `RST_FLAG;
            carry_flag              <= `RST_FLAG;
            global_interrupt_enable <= `RST_INT_EN;
        end else begin
            state                   <= next_state;
            cur                     <= next_cur;
            instr_ready             <= next_instr_ready;
            file_req                <= next_file_req;
            stack_pop               <= next_stack_pop;
            pc                      <= next_pc;
            working                 <= next_working;
            zero_flag               <= next_zero_flag;
            carry_flag              <= next_carry_flag;
            global_interrupt_enable <= next_global_interrupt_enable;
        end
    end

    // Software read port; data stand only in the cycle after the strobe.
    always_comb begin
        next_reg_rdata = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                `REG_CTRL: begin
                    next_reg_rdata[`CTRL_INT_EN_BIT] = global_interrupt_enable;
                end
                `REG_WORKING: begin
                    next_reg_rdata = working;
                end
                `REG_STATUS: begin
                    next_reg_rdata[`STATUS_Z_BIT] = zero_flag;
                    next_reg_rdata[`STATUS_C_BIT] = carry_flag;
                end
                `REG_PC_LO: begin
                    next_reg_rdata = pc[7:0];
                end
                `REG_PC_HI: begin
                    next_reg_rdata[`PC_HI_W-1:0] = pc[12:8];
                end
                default: begin
                    next_reg_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

endmodule
`default_nettype wire

// file: verification/exec_chk.sv
// Concurrent checks on the executor ports.
`timescale 1ns/1ps
`default_nettype none
module exec_chk #(
    parameter int CYC_DIV = 4
) (
    input wire logic                mclk,
    input wire logic                resetn,
    input wire logic                instr_ready,
    input wire exec_pkg::file_req_s file_req,
    input wire logic [12:0]         stack_top_entry,
    input wire logic                stack_pop,
    input wire logic [12:0]         pc,
    input wire logic                zero_flag,
    input wire logic                carry_flag,
    input wire logic                global_interrupt_enable,
    input wire logic                reg_write
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    AST_POP_PC: assert property (stack_pop |-> pc == $past(stack_top_entry))
        else $error("pc not loaded from stack top");
    AST_RET_BUSY: assert property (stack_pop |-> !instr_ready [*2])
        else $error("return finished in one cycle");
    AST_RET_DONE: assert property (stack_pop |-> ##[1:8] instr_ready)
        else $error("return never finished");
    AST_READ_BUSY: assert property (file_req.rd |-> !instr_ready ##[1:3] instr_ready)
        else $error("file read handshake wrong");
    AST_WR_PULSE: assert property (file_req.wr |=> !file_req.wr)
        else $error("file write longer than one cycle");
    AST_CARRY_SRC: assert property ($changed(carry_flag) && !$past(reg_write) |->
        $past(file_req.rd) || $past(file_req.rd, 2))
        else $error("carry changed without a rotate");
    AST_ZERO_SRC: assert property ($changed(zero_flag) && !$past(reg_write) |->
        $past(file_req.rd) || $past(file_req.rd, 2))
        else $error("zero changed without a move");
    AST_GIE_SRC: assert property ($rose(global_interrupt_enable) && !$past(reg_write) |-> stack_pop)
        else $error("interrupt enable set outside a return");
    AST_PC_STEP: assert property ($changed(pc) && !stack_pop |-> pc == $past(pc) + 13'h1)
        else $error("pc did not step by one");
endmodule
`default_nettype wire

// file: verification/file_model.sv
// Behavioural model of the data file registers.
`timescale 1ns/1ps
`default_nettype none
module file_model (
    input  wire logic                mclk,
    input  wire exec_pkg::file_req_s file_req,
    output logic [7:0]               file_rd_data
);
    logic [7:0] mem [0:127];
    logic       rd_q = 1'b0;
    logic [7:0] last = 8'h00;
    always @(posedge mclk) begin
        rd_q <= file_req.rd;
        if (file_req.wr) begin
            mem[file_req.addr] <= file_req.data;
        end
        if (file_req.rd || rd_q) begin
            last <= file_rd_data;
        end
    end
    // Outside a read the lines show the inverse of the last answer.
    assign file_rd_data = (file_req.rd || rd_q) ? mem[file_req.addr] : ~last;
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking testbench of the instruction executor.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int CDIV = 3;
    logic                mclk;
    logic                resetn;
    logic                instr_valid;
    logic                instr_ready;
    logic [13:0]         instr_word;
    exec_pkg::file_req_s file_req;
    logic [7:0]          file_rd_data;
    logic [12:0]         stack_top_entry;
    logic                stack_pop;
    logic [12:0]         pc;
    logic [7:0]          working;
    logic                zero_flag;
    logic                carry_flag;
    logic                global_interrupt_enable;
    logic [2:0]          reg_addr;
    logic [7:0]          reg_wdata;
    logic                reg_write;
    logic                reg_read;
    logic [7:0]          reg_rdata;
    logic [7:0]          d;
    logic [12:0]         p;
    int                  err_count = 0;
    int                  samples_checked = 0;
    int                  busy;
    int                  cycles = 0;
    move_return_rotate_exec #(.CYC_DIV(CDIV)) dut (.mclk(mclk), .resetn(resetn),
        .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
        .file_req(file_req), .file_rd_data(file_rd_data), .stack_top_entry(stack_top_entry),
        .stack_pop(stack_pop), .pc(pc), .working(working), .zero_flag(zero_flag),
        .carry_flag(carry_flag), .global_interrupt_enable(global_interrupt_enable),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata));
    file_model u_file (.mclk(mclk), .file_req(file_req), .file_rd_data(file_rd_data));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
        @(negedge mclk);
    endtask
    task automatic reg_rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        @(negedge mclk);
        v = reg_rdata;
    endtask
    task automatic exec(input logic [13:0] w);
        logic [12:0] p0;
        int          n;
        p0 = pc;
        n = 0;
        busy = 0;
        @(posedge mclk);
        instr_word  <= w;
        instr_valid <= 1'b1;
        do begin
            @(negedge mclk);
            n++;
        end while (pc === p0 && n < 40);
        @(posedge mclk);
        instr_valid <= 1'b0;
        @(negedge mclk);
        while (instr_ready !== 1'b1 && busy < 40) begin
            busy++;
            @(negedge mclk);
        end
        @(negedge mclk);
    endtask
    task automatic t_move();
        u_file.mem[7'h15] = 8'h00;
        u_file.mem[7'h7f] = 8'h80;
        reg_wr(3'h2, 8'h00);
        exec(14'h0815);
        check(working, 8'h00);
        check(zero_flag, 1'b1);
        reg_wr(3'h1, 8'h3c);
        exec(14'h08ff);
        check({working, u_file.mem[7'h7f]}, 16'h3c80);
        check(zero_flag, 1'b0);
        $display("move test done");
    endtask
    task automatic t_lit_store();
        reg_wr(3'h2, 8'h05);
        exec(14'h33ff);
        check(working, 8'hff);
        check({zero_flag, carry_flag}, 2'b11);
        exec(14'h30a7);
        exec(14'h00ff);
        check(u_file.mem[7'h7f], 8'ha7);
        check({zero_flag, carry_flag}, 2'b11);
        reg_rd(3'h1, d);
        check(d, 8'ha7);
        $display("literal and store test done");
    endtask
    task automatic t_rot();
        u_file.mem[7'h10] = 8'h80;
        u_file.mem[7'h11] = 8'h41;
        reg_wr(3'h2, 8'h01);
        exec(14'h0d10);
        check(working, 8'h01);
        check({zero_flag, carry_flag}, 2'b01);
        exec(14'h0d91);
        check({working, u_file.mem[7'h11]}, 16'h0183);
        check({zero_flag, carry_flag}, 2'b00);
        $display("rotate test done");
    endtask
    task automatic t_ret();
        @(posedge mclk);
        stack_top_entry <= 13'h1abc;
        exec(14'h34a5);
        check({3'h0, pc}, 16'h1abc);
        check({working, 6'h00, zero_flag, carry_flag}, 16'ha500);
        check(busy > 0, 1'b1);
        reg_rd(3'h3, d);
        check(d, 8'hbc);
        reg_rd(3'h4, d);
        check(d, 8'h1a);
        reg_wr(3'h0, 8'h00);
        @(posedge mclk);
        stack_top_entry <= 13'h0123;
        exec(14'h0009);
        check({3'h0, pc}, 16'h0123);
        check({global_interrupt_enable, zero_flag, carry_flag}, 3'h4);
        $display("return test done");
    endtask
    task automatic t_nop();
        p = pc;
        exec(14'h0060);
        check({3'h0, pc}, {3'h0, p + 13'h1});
        check({working, 6'h00, zero_flag, carry_flag}, 16'ha500);
        check(busy, 16'h0000);
        reg_rd(3'h7, d);
        check(d, 8'h00);
        $display("no-operation test done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        resetn = 1'b0;
        instr_valid = 1'b0;
        instr_word = 14'h0000;
        stack_top_entry = 13'h0000;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        @(negedge mclk);
        t_move();
        t_lit_store();
        t_rot();
        t_ret();
        t_nop();
        tally_and_finish();
    end
endmodule
bind move_return_rotate_exec exec_chk #(.CYC_DIV(CYC_DIV)) u_chk (.mclk(mclk), .resetn(resetn),
    .instr_ready(instr_ready), .file_req(file_req), .stack_top_entry(stack_top_entry),
    .stack_pop(stack_pop), .pc(pc), .zero_flag(zero_flag), .carry_flag(carry_flag),
    .global_interrupt_enable(global_interrupt_enable), .reg_write(reg_write));
`default_nettype wire
